// [rtl/vrc_regfile.sv]
// Vector register file with operand and result reservations and automatic chaining.
// Assumes functional units and the memory port sit on the channel streams, one per channel.
//
// Notes on behaviour
// - Eight registers of 64 elements, 64 bits each, by designator and index.
// - Every operation reads and writes element 0 first.
// - One element per clock; stop when count reaches captured length.
// - Memory transfers use base, signed stride, length; from element 0.
// - Stream gaps never break chaining; they only lengthen the operation.
// - Single word moves between a scalar and one vector element.
// - Reading a register still receiving results chains automatically.
// - An operation holds its channel busy until all elements are done.
// - Scalar work sees units free except busy floating point and memory.
// - Two loads and one store may run together on distinct registers.
// - Each register has operand and result reservations, set at issue.
// - A result-only reserved register is readable anywhere in its stream.
// - Issue by element 0 arrival chains fully; later issue chains partially.
// - An operand-reserved register is granted to nobody; issue stalls.
// - One operation may use the same register as source and destination.
// - A register feeds at most one operation and receives at most one.
// - Length and scalar are captured per operation, not reserved.
// - Base and stride are captured at issue and free right after.
// - Element count is 7 bits; writing zero means 64.
// - Count governs vector opcodes; loaded and read back via address registers.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_map.svh"
module vrc_regfile
	import vrc_pkg::*;
(
	// Clock and reset
	input  wire logic                                clock,
	input  wire logic                                rst_n,
	// Element count, loaded from and read back to an address register
	input  wire logic                                ec_wr,
	input  wire logic [`VRC_CW-1:0]                  ec_wdata,
	output logic      [`VRC_CW-1:0]                  ec_r,
	// Instruction issue
	input  wire logic                                iss_valid,
	input  wire vrc_issue_type                       iss,
	output logic                                     iss_ack_r,
	// Operand streams towards units and memory
	input  wire logic [`VRC_NCH-1:0]                 opd_req,
	output logic      [`VRC_NCH-1:0]                 opd_valid_r,
	output logic      [`VRC_NCH-1:0]                 opd_last_r,
	output logic      [`VRC_NCH-1:0][`VRC_DW-1:0]    opd_j,
	output logic      [`VRC_NCH-1:0][`VRC_DW-1:0]    opd_k,
	output logic      [`VRC_NCH-1:0][`VRC_DW-1:0]    opd_scalar,
	output logic      [`VRC_NCH-1:0][`VRC_AW-1:0]    mem_addr_r,
	// Result streams from units and memory
	input  wire logic [`VRC_NCH-1:0]                 res_valid,
	input  wire logic [`VRC_NCH-1:0][`VRC_DW-1:0]    res_data,
	// Status
	output logic      [`VRC_NCH-1:0]                 chan_busy_r,
	output logic      [`VRC_NCH-1:0]                 chain_part_r,
	output logic      [`VRC_NREG-1:0]                opd_rsv_r,
	output logic      [`VRC_NREG-1:0]                res_rsv_r,
	// Single word access from a scalar register
	input  wire logic                                sx_valid,
	input  wire logic                                sx_write,
	input  wire logic [`VRC_RW-1:0]                  sx_reg,
	input  wire logic [`VRC_EW-1:0]                  sx_elem,
	input  wire logic [`VRC_DW-1:0]                  sx_wdata,
	output logic                                     sx_ack_r,
	output logic      [`VRC_DW-1:0]                  sx_rdata
);
	localparam int NCH = `VRC_NCH;
	localparam int NR  = 2 * NCH + 1;
	localparam int NW  = NCH + 1;

	// Channel progress.
	logic [NCH-1:0]              reading, writing, rd_last, wr_last, rd_go, wr_go, start;
	logic [NCH-1:0]              still_rd, still_wr;
	logic [NCH-1:0][`VRC_CW-1:0] rd_cnt, wr_cnt;
	logic [NCH-1:0][`VRC_AW-1:0] addr_q;
	// Register designators captured at issue, per channel.
	logic [NCH-1:0][`VRC_RW-1:0] src_j_r, src_j_nxt, src_k_r, src_k_nxt, dst_r, dst_nxt;
	logic [NCH-1:0]              use_j_r, use_j_nxt, use_k_r, use_k_nxt, use_d_r, use_d_nxt;
	// Issue and output next values.
	logic                        iss_ok, iss_go, sx_go;
	logic                        iss_ack_nxt, sx_ack_nxt;
	logic [`VRC_CW-1:0]          ec_nxt;
	logic [NCH-1:0]              opd_valid_nxt, opd_last_nxt, busy_nxt, part_nxt;
	logic [NCH-1:0][`VRC_AW-1:0] mem_addr_nxt;
	logic [`VRC_NREG-1:0]        opd_rsv_nxt, res_rsv_nxt;
	// Memory ports.
	logic [NR-1:0]               m_re;
	logic [NR-1:0][`VRC_MAW-1:0] m_raddr;
	logic [NR-1:0][`VRC_DW-1:0]  m_rdata;
	logic [NW-1:0]               m_we;
	logic [NW-1:0][`VRC_MAW-1:0] m_waddr;
	logic [NW-1:0][`VRC_DW-1:0]  m_wdata;

	// -----------------------------------------------------------------
	// Chaining helpers
	// -----------------------------------------------------------------

	// True while element e of register s is not yet written by another channel.
	function automatic logic chain_wait(input logic [`VRC_RW-1:0] s,
	                                    input logic [`VRC_CW-1:0] e, input int c);
		chain_wait = 1'b0;
		for (int d = 0; d < NCH; d++) begin
			if (d != c && writing[d] && use_d_r[d] && dst_r[d] == s && wr_cnt[d] <= e)
				chain_wait = 1'b1;
		end
	endfunction : chain_wait

	// True when register s already has results in it from a running producer.
	function automatic logic late_src(input logic [`VRC_RW-1:0] s);
		late_src = 1'b0;
		for (int d = 0; d < NCH; d++) begin
			if (writing[d] && use_d_r[d] && dst_r[d] == s && wr_cnt[d] != '0)
				late_src = 1'b1;
		end
	endfunction : late_src

	// -----------------------------------------------------------------
	// Issue decision
	// -----------------------------------------------------------------

	// A result-only reservation never blocks a reader: that is the chaining case.
	always_comb begin
		iss_ok = !(reading[iss.chan] || writing[iss.chan]);
		if (iss.use_j && opd_rsv_r[iss.src_j]) iss_ok = 1'b0;
		if (iss.use_k && opd_rsv_r[iss.src_k]) iss_ok = 1'b0;
		if (iss.use_dst && (opd_rsv_r[iss.dst] || res_rsv_r[iss.dst])) iss_ok = 1'b0;
		iss_go = iss_valid && !iss_ack_r && iss_ok;
		for (int c = 0; c < NCH; c++) begin
			start[c] = iss_go && (iss.chan == c[`VRC_CHW-1:0]);
		end
	end

	// -----------------------------------------------------------------
	// Operation channels
	// -----------------------------------------------------------------

	for (genvar g = 0; g < NCH; g++) begin : g_chan
		vrc_chan u_chan (
			.clock    (clock),
			.rst_n    (rst_n),
			.start    (start[g]),
			.len      (ec_r),
			.has_dst  (iss.use_dst),
			.scalar   (iss.scalar),
			.base     (iss.base),
			.stride   (iss.stride),
			.rd_go    (rd_go[g]),
			.wr_go    (wr_go[g]),
			.reading  (reading[g]),
			.writing  (writing[g]),
			.rd_last  (rd_last[g]),
			.wr_last  (wr_last[g]),
			.rd_cnt_r (rd_cnt[g]),
			.wr_cnt_r (wr_cnt[g]),
			.addr_r   (addr_q[g]),
			.scalar_r (opd_scalar[g])
		);
	end

	// Element steps; a missing request or result is a gap and only costs time.
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			rd_go[c] = opd_req[c] && reading[c]
			           && !(use_j_r[c] && chain_wait(src_j_r[c], rd_cnt[c], c))
			           && !(use_k_r[c] && chain_wait(src_k_r[c], rd_cnt[c], c));
			wr_go[c] = res_valid[c] && writing[c];
			still_rd[c] = reading[c] && !(rd_go[c] && rd_last[c]);
			still_wr[c] = writing[c] && !(wr_go[c] && wr_last[c]);
		end
	end

	// -----------------------------------------------------------------
	// Captured designators and reservations
	// -----------------------------------------------------------------

	// Reservations are rebuilt from live channels, so a new issue always wins over a clear.
	always_comb begin
		src_j_nxt   = src_j_r;
		src_k_nxt   = src_k_r;
		dst_nxt     = dst_r;
		use_j_nxt   = use_j_r;
		use_k_nxt   = use_k_r;
		use_d_nxt   = use_d_r;
		opd_rsv_nxt = '0;
		res_rsv_nxt = '0;
		for (int c = 0; c < NCH; c++) begin
			if (start[c]) begin
				src_j_nxt[c] = iss.src_j;
				src_k_nxt[c] = iss.src_k;
				dst_nxt[c]   = iss.dst;
				use_j_nxt[c] = iss.use_j;
				use_k_nxt[c] = iss.use_k;
				use_d_nxt[c] = iss.use_dst;
			end
			if (still_rd[c] && use_j_r[c]) opd_rsv_nxt[src_j_r[c]] = 1'b1;
			if (still_rd[c] && use_k_r[c]) opd_rsv_nxt[src_k_r[c]] = 1'b1;
			if (still_wr[c] && use_d_r[c]) res_rsv_nxt[dst_r[c]]   = 1'b1;
		end
		if (iss_go && iss.use_j)   opd_rsv_nxt[iss.src_j] = 1'b1;
		if (iss_go && iss.use_k)   opd_rsv_nxt[iss.src_k] = 1'b1;
		if (iss_go && iss.use_dst) res_rsv_nxt[iss.dst]   = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			src_j_r   <= '0;
			src_k_r   <= '0;
			dst_r     <= '0;
			use_j_r   <= '0;
			use_k_r   <= '0;
			use_d_r   <= '0;
			opd_rsv_r <= '0;
			res_rsv_r <= '0;
		end else begin
			src_j_r   <= src_j_nxt;
			src_k_r   <= src_k_nxt;
			dst_r     <= dst_nxt;
			use_j_r   <= use_j_nxt;
			use_k_r   <= use_k_nxt;
			use_d_r   <= use_d_nxt;
			opd_rsv_r <= opd_rsv_nxt;
			res_rsv_r <= res_rsv_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Register storage
	// -----------------------------------------------------------------

	// Each channel has its own pair of read ports and one write port, which is what
	// lets two loads and a store run side by side on distinct registers.
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			m_re[2*c]     = rd_go[c] && use_j_r[c];
			m_re[2*c+1]   = rd_go[c] && use_k_r[c];
			m_raddr[2*c]  = {src_j_r[c], rd_cnt[c][`VRC_EW-1:0]};
			m_raddr[2*c+1]= {src_k_r[c], rd_cnt[c][`VRC_EW-1:0]};
			m_we[c]       = wr_go[c] && use_d_r[c];
			m_waddr[c]    = {dst_r[c], wr_cnt[c][`VRC_EW-1:0]};
			m_wdata[c]    = res_data[c];
			opd_j[c]      = m_rdata[2*c];
			opd_k[c]      = m_rdata[2*c+1];
		end
		// Single word port; refused while the register takes part in vector work.
		sx_go          = sx_valid && !sx_ack_r && !opd_rsv_r[sx_reg] && !res_rsv_r[sx_reg];
		m_re[NR-1]     = sx_go && !sx_write;
		m_raddr[NR-1]  = {sx_reg, sx_elem};
		m_we[NW-1]     = sx_go && sx_write;
		m_waddr[NW-1]  = {sx_reg, sx_elem};
		m_wdata[NW-1]  = sx_wdata;
		sx_rdata       = m_rdata[NR-1];
	end

	vrc_mem #(
		.NR (NR),
		.NW (NW)
	) u_mem (
		.clock (clock),
		.re    (m_re),
		.raddr (m_raddr),
		.rdata (m_rdata),
		.we    (m_we),
		.waddr (m_waddr),
		.wdata (m_wdata)
	);

	// -----------------------------------------------------------------
	// Element count and output registers
	// -----------------------------------------------------------------

	// Busy status lets scalar issue see floating point and memory channels in use.
	always_comb begin
		ec_nxt = ec_r;
		if (ec_wr) ec_nxt = (ec_wdata[`VRC_EW-1:0] == '0) ? `VRC_EC_FULL
		                  : {1'b0, ec_wdata[`VRC_EW-1:0]};
		iss_ack_nxt = iss_go;
		sx_ack_nxt  = sx_go;
		for (int c = 0; c < NCH; c++) begin
			opd_valid_nxt[c] = rd_go[c];
			opd_last_nxt[c]  = rd_go[c] && rd_last[c];
			mem_addr_nxt[c]  = rd_go[c] ? addr_q[c] : mem_addr_r[c];
			busy_nxt[c]      = start[c] || still_rd[c] || still_wr[c];
			part_nxt[c]      = chain_part_r[c];
			if (start[c])
				part_nxt[c] = (iss.use_j && late_src(iss.src_j))
				              || (iss.use_k && late_src(iss.src_k));
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ec_r         <= `VRC_EC_RST;
			iss_ack_r    <= 1'b0;
			sx_ack_r     <= 1'b0;
			opd_valid_r  <= '0;
			opd_last_r   <= '0;
			mem_addr_r   <= '0;
			chan_busy_r  <= '0;
			chain_part_r <= '0;
		end else begin
			ec_r         <= ec_nxt;
			iss_ack_r    <= iss_ack_nxt;
			sx_ack_r     <= sx_ack_nxt;
			opd_valid_r  <= opd_valid_nxt;
			opd_last_r   <= opd_last_nxt;
			mem_addr_r   <= mem_addr_nxt;
			chan_busy_r  <= busy_nxt;
			chain_part_r <= part_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_ec_zero_full: assert property (ec_wr && ec_wdata == '0 |=> ec_r == `VRC_EC_FULL)
		else $error("zero count did not read back as full length");
	a_first_elem: assert property (start[0] |=> rd_cnt[0] == '0 && reading[0])
		else $error("operation did not begin at element zero");
	a_one_step: assert property (rd_go[0] |=>
		rd_cnt[0] == $past(rd_cnt[0]) + `VRC_CNT_ONE && opd_valid_r[0])
		else $error("read stream did not advance by one element");
	a_no_opd_share: assert property (iss_go && iss.use_j |-> !opd_rsv_r[iss.src_j])
		else $error("operand register granted twice");
	a_no_dst_share: assert property (iss_go && iss.use_dst |->
		!res_rsv_r[iss.dst] && !opd_rsv_r[iss.dst])
		else $error("result register granted twice");
	a_rsv_set: assert property (iss_go && iss.use_dst && iss.use_j |=>
		res_rsv_r[$past(iss.dst)] && opd_rsv_r[$past(iss.src_j)])
		else $error("issue did not set reservations");
	a_no_overtake: assert property (rd_go[1] && use_j_r[1] && use_d_r[0]
		&& writing[0] && dst_r[0] == src_j_r[1] |-> wr_cnt[0] > rd_cnt[1])
		else $error("chained read overtook the result stream");
	a_busy_hold: assert property (reading[0] && !rd_go[0] |=> chan_busy_r[0])
		else $error("channel released before its last element");
	a_opd_clear: assert property (rd_go[1] && rd_last[1] && use_j_r[1] |=>
		!opd_rsv_r[src_j_r[1]])
		else $error("operand reservation outlived the last read");
	a_sx_refused: assert property (sx_valid && res_rsv_r[sx_reg] |=> !sx_ack_r)
		else $error("single word access hit a reserved register");

	c_chain_full: cover property (start[1] && iss.use_j && res_rsv_r[iss.src_j]
		&& !late_src(iss.src_j));
	c_chain_part: cover property (start[1] ##1 chain_part_r[1]);
	c_par_mem: cover property (m_we[0] && m_we[1] && m_re[4]);
	c_recursion: cover property (iss_go && iss.use_j && iss.use_dst && iss.src_j == iss.dst);
endmodule : vrc_regfile
`default_nettype wire

// [rtl/vrc_map.svh]
// Constants of the vector register file with chaining: sizes, widths and reset values.
// Assumes inclusion by its bare name; holds definitions only.
`ifndef VRC_MAP_SVH
`define VRC_MAP_SVH
`define VRC_NREG    8
`define VRC_RW      3
`define VRC_EW      6
`define VRC_DW      64
`define VRC_CW      7
`define VRC_AW      24
`define VRC_NCH     4
`define VRC_CHW     2
`define VRC_MAW     9
`define VRC_EC_FULL 7'h40
`define VRC_EC_RST  7'h40
`define VRC_CNT_ONE 7'h01
`endif

// [rtl/vrc_pkg.sv]
// Types shared by the vector register file: channel states and the issue record.
// Assumes the constants header sits beside it.
`include "vrc_map.svh"
package vrc_pkg;
	typedef enum logic {CH_IDLE, CH_BUSY} vrc_state_type;

	// One issued vector instruction, as seen by the register file.
	typedef struct packed {
		logic [`VRC_CHW-1:0] chan;
		logic [`VRC_RW-1:0]  src_j;
		logic                use_j;
		logic [`VRC_RW-1:0]  src_k;
		logic                use_k;
		logic [`VRC_RW-1:0]  dst;
		logic                use_dst;
		logic [`VRC_DW-1:0]  scalar;
		logic [`VRC_AW-1:0]  base;
		logic [`VRC_AW-1:0]  stride;
	} vrc_issue_type;
endpackage : vrc_pkg

// [rtl/vrc_mem.sv]
// Storage of the eight vector registers, with registered read ports.
// Assumes the caller never writes one word from two ports in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_map.svh"
module vrc_mem
	import vrc_pkg::*;
#(
	parameter int NR = 1,
	parameter int NW = 1
) (
	// Clock
	input  wire logic                           clock,
	// Read ports
	input  wire logic [NR-1:0]                  re,
	input  wire logic [NR-1:0][`VRC_MAW-1:0]    raddr,
	output logic      [NR-1:0][`VRC_DW-1:0]     rdata,
	// Write ports
	input  wire logic [NW-1:0]                  we,
	input  wire logic [NW-1:0][`VRC_MAW-1:0]    waddr,
	input  wire logic [NW-1:0][`VRC_DW-1:0]     wdata
);
	logic [`VRC_DW-1:0] words [0:(1 << `VRC_MAW) - 1];

	// Words carry no reset; software always writes an element before it reads it.
	always_ff @(posedge clock) begin
		for (int w = 0; w < NW; w++) begin
			if (we[w]) words[waddr[w]] <= wdata[w];
		end
		for (int r = 0; r < NR; r++) begin
			if (re[r]) rdata[r] <= words[raddr[r]];
		end
	end
endmodule : vrc_mem
`default_nettype wire

// [rtl/vrc_chan.sv]
// One operation channel: captured length, scalar, address and stride, with element counters.
// Assumes start only arrives while the channel is idle.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_map.svh"
module vrc_chan
	import vrc_pkg::*;
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Operation start
	input  wire logic                 start,
	input  wire logic [`VRC_CW-1:0]   len,
	input  wire logic                 has_dst,
	input  wire logic [`VRC_DW-1:0]   scalar,
	input  wire logic [`VRC_AW-1:0]   base,
	input  wire logic [`VRC_AW-1:0]   stride,
	// Element steps
	input  wire logic                 rd_go,
	input  wire logic                 wr_go,
	// Progress
	output logic                      reading,
	output logic                      writing,
	output logic                      rd_last,
	output logic                      wr_last,
	output logic [`VRC_CW-1:0]        rd_cnt_r,
	output logic [`VRC_CW-1:0]        wr_cnt_r,
	output logic [`VRC_AW-1:0]        addr_r,
	output logic [`VRC_DW-1:0]        scalar_r
);
	vrc_state_type      state_r, state_nxt;
	logic [`VRC_CW-1:0] len_r, len_nxt, rd_cnt_nxt, wr_cnt_nxt;
	logic [`VRC_AW-1:0] stride_r, stride_nxt, addr_nxt;
	logic [`VRC_DW-1:0] scalar_nxt;

	// Length, scalar, base and stride are private copies, so later writes cannot disturb us.
	always_comb begin
		state_nxt  = state_r;
		len_nxt    = len_r;
		rd_cnt_nxt = rd_cnt_r;
		wr_cnt_nxt = wr_cnt_r;
		addr_nxt   = addr_r;
		stride_nxt = stride_r;
		scalar_nxt = scalar_r;
		case (state_r)
			CH_IDLE: begin
				if (start) begin
					state_nxt  = CH_BUSY;
					len_nxt    = len;
					rd_cnt_nxt = '0;
					wr_cnt_nxt = has_dst ? '0 : len;
					addr_nxt   = base;
					stride_nxt = stride;
					scalar_nxt = scalar;
				end
			end
			CH_BUSY: begin
				if (rd_go) begin
					rd_cnt_nxt = rd_cnt_r + `VRC_CNT_ONE;
					addr_nxt   = addr_r + stride_r;
				end
				if (wr_go) wr_cnt_nxt = wr_cnt_r + `VRC_CNT_ONE;
				// The unit stays held until every element is read and written.
				if (rd_cnt_nxt == len_r && wr_cnt_nxt == len_r) state_nxt = CH_IDLE;
			end
			default: state_nxt = CH_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r  <= CH_IDLE;
			len_r    <= `VRC_EC_RST;
			rd_cnt_r <= '0;
			wr_cnt_r <= '0;
			addr_r   <= '0;
			stride_r <= '0;
			scalar_r <= '0;
		end else begin
			state_r  <= state_nxt;
			len_r    <= len_nxt;
			rd_cnt_r <= rd_cnt_nxt;
			wr_cnt_r <= wr_cnt_nxt;
			addr_r   <= addr_nxt;
			stride_r <= stride_nxt;
			scalar_r <= scalar_nxt;
		end
	end

	// Progress flags; a stalled cycle simply leaves the counters alone.
	assign reading = (state_r == CH_BUSY) && (rd_cnt_r != len_r);
	assign writing = (state_r == CH_BUSY) && (wr_cnt_r != len_r);
	assign rd_last = (rd_cnt_r + `VRC_CNT_ONE) == len_r;
	assign wr_last = (wr_cnt_r + `VRC_CNT_ONE) == len_r;
endmodule : vrc_chan
`default_nettype wire

// [dv/vrc_partner.sv]
// Model of the functional units and memory port on the four channel streams.
// Assumes the register file's channel outputs; one fixed-latency pipe per channel.
`timescale 1ns/1ps
`default_nettype none
module vrc_partner
	import vrc_pkg::*;
#(
	parameter int LAT = 3
) (
	// Clock and reset
	input  wire logic                              clock,
	input  wire logic                              rst_n,
	// Operand side
	input  wire logic [`VRC_NCH-1:0]               chan_busy_r,
	input  wire logic [`VRC_NCH-1:0]               opd_valid_r,
	input  wire logic [`VRC_NCH-1:0][`VRC_DW-1:0]  opd_j,
	input  wire logic [`VRC_NCH-1:0][`VRC_AW-1:0]  mem_addr_r,
	input  wire logic [`VRC_NCH-1:0]               load,
	input  wire logic [`VRC_NCH-1:0]               stall,
	output logic      [`VRC_NCH-1:0]               opd_req,
	// Result side
	output logic      [`VRC_NCH-1:0]               res_valid,
	output logic      [`VRC_NCH-1:0][`VRC_DW-1:0]  res_data
);
	logic [LAT-1:0][`VRC_NCH-1:0]              v_r;
	logic [LAT-1:0][`VRC_NCH-1:0][`VRC_DW-1:0] d_r;

	// Stall makes gaps, as a memory conflict would.
	assign opd_req = chan_busy_r & ~stall;

	// Fixed latency pipe; a load returns its address, a unit returns the operand plus one.
	always @(posedge clock) begin
		v_r <= rst_n ? {v_r[LAT-2:0], opd_valid_r} : '0;
		for (int c = 0; c < `VRC_NCH; c++) begin
			d_r[0][c] <= load[c] ? {40'h0, mem_addr_r[c]} : opd_j[c] + 64'h1;
		end
		for (int s = 1; s < LAT; s++) begin
			d_r[s] <= d_r[s-1];
		end
	end

	// Between results the data lines show the inverse, so stale data never matches.
	always_comb begin
		res_valid = v_r[LAT-1];
		for (int c = 0; c < `VRC_NCH; c++) begin
			res_data[c] = v_r[LAT-1][c] ? d_r[LAT-1][c] : ~d_r[LAT-1][c];
		end
	end
endmodule : vrc_partner
`default_nettype wire

// [dv/test_vector_register_chaining.sv]
// Self-checking bench of the vector register file with chaining.
// Assumes the partner model on the channel streams; 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_vector_register_chaining;
	import vrc_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0, ec_wr = 1'b0, iss_valid = 1'b0, iss_ack_r, sx_ack_r;
	logic sx_valid = 1'b0, sx_write = 1'b0;
	logic [6:0] ec_wdata = '0, ec_r;
	logic [2:0] sx_reg = '0;
	logic [5:0] sx_elem = '0;
	logic [63:0] sx_wdata = '0, sx_rdata;
	vrc_issue_type iss = '0;
	logic [3:0] opd_req, opd_valid_r, opd_last_r, res_valid, chan_busy_r, chain_part_r;
	logic [3:0] load = '0, stall = '0;
	logic [3:0][63:0] opd_j, opd_scalar, res_data;
	logic [3:0][23:0] mem_addr_r;
	logic [7:0] opd_rsv_r, res_rsv_r;
	int fail_count = 0, checks = 0, cyc = 0, lasts = 0;

	vrc_regfile DUT (.clock, .rst_n, .ec_wr, .ec_wdata, .ec_r, .iss_valid, .iss, .iss_ack_r,
		.opd_req, .opd_valid_r, .opd_last_r, .opd_j, .opd_k(), .opd_scalar, .mem_addr_r,
		.res_valid, .res_data, .chan_busy_r, .chain_part_r, .opd_rsv_r, .res_rsv_r,
		.sx_valid, .sx_write, .sx_reg, .sx_elem, .sx_wdata, .sx_ack_r, .sx_rdata);
	vrc_partner far (.clock, .rst_n, .chan_busy_r, .opd_valid_r, .opd_j, .mem_addr_r, .load,
		.stall, .opd_req, .res_valid, .res_data);

	always #50 clock = ~clock;
	// A hang counts as a mismatch; the tests need well under this many cycles.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			give_verdict();
		end
	end

	// Every operation flags exactly one final operand step; sampled mid-cycle where it is settled.
	always @(negedge clock) lasts += $countones(opd_last_r);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic step();
		@(posedge clock);
		#1;
	endtask : step
	function automatic vrc_issue_type mk(input logic [1:0] c, input logic [2:0] j,
		input logic uj, input logic [2:0] d, input logic [23:0] b, input logic [23:0] s);
		mk = '{chan:c, src_j:j, use_j:uj, src_k:3'h0, use_k:1'b0, dst:d, use_dst:1'b1,
			scalar:64'h0, base:b, stride:s};
	endfunction : mk
	task automatic issue(input vrc_issue_type r);
		iss = r;
		iss_valid = 1'b1;
		for (int n = 0; n < 300 && iss_ack_r !== 1'b1; n++) step();
		iss_valid = 1'b0;
	endtask : issue
	task automatic set_ec(input logic [6:0] v);
		ec_wdata = v;
		ec_wr = 1'b1;
		step();
		ec_wr = 1'b0;
		step();
	endtask : set_ec
	task automatic sx(input logic w, input logic [2:0] r, input logic [5:0] e,
		input logic [63:0] wd, input logic [63:0] exp);
		sx_write = w;
		sx_reg = r;
		sx_elem = e;
		sx_wdata = wd;
		sx_valid = 1'b1;
		for (int n = 0; n < 300 && sx_ack_r !== 1'b1; n++) step();
		if (!w) chk(sx_rdata, exp);
		sx_valid = 1'b0;
		step();
	endtask : sx
	task automatic wait_idle();
		for (int n = 0; n < 400 && chan_busy_r !== 4'h0; n++) step();
		step();
		chk(res_rsv_r, 8'h00);
		chk(opd_rsv_r, 8'h00);
	endtask : wait_idle

	// Load of five elements with a negative stride; count rewritten mid-run.
	task automatic t_load();
		sx(1'b1, 3'h1, 6'h05, 64'h5a, 64'h0);
		set_ec(7'h05);
		load = 4'h1;
		issue(mk(2'h0, 3'h0, 1'b0, 3'h1, 24'h000100, 24'hfffffe));
		chk(res_rsv_r, 8'h02);
		set_ec(7'h03);
		chk(ec_r, 7'h03);
		sx(1'b0, 3'h1, 6'h00, 64'h0, 64'h100);
		wait_idle();
		sx(1'b0, 3'h1, 6'h00, 64'h0, 64'h100);
		sx(1'b0, 3'h1, 6'h04, 64'h0, 64'hf8);
		sx(1'b0, 3'h1, 6'h05, 64'h0, 64'h5a);
		$display("test load done");
	endtask : t_load

	// Load of 64 elements chained into a unit after a delay, with gaps in the stream.
	task automatic t_chain(input logic [2:0] s, input logic [2:0] d, input int dly,
		input logic part);
		set_ec(7'h00);
		chk(ec_r, 7'h40);
		load = 4'h1;
		issue(mk(2'h0, 3'h0, 1'b0, s, 24'h000200, 24'h000001));
		stall = 4'h1;
		repeat (2) step();
		stall = 4'h0;
		repeat (dly) step();
		issue(mk(2'h1, s, 1'b1, d, 24'h0, 24'h0));
		chk(chain_part_r[1], part);
		chk(opd_rsv_r[s], 1'b1);
		stall = 4'h1;
		repeat (3) step();
		stall = 4'h0;
		wait_idle();
		sx(1'b0, d, 6'h00, 64'h0, 64'h201);
		sx(1'b0, d, 6'h3f, 64'h0, 64'h240);
		$display("test chain done");
	endtask : t_chain

	// One operation reading and writing the same register, with a scalar captured at issue.
	task automatic t_same();
		vrc_issue_type r;
		r = mk(2'h1, 3'h3, 1'b1, 3'h3, 24'h0, 24'h0);
		r.scalar = 64'h3c;
		issue(r);
		iss = '0;
		step();
		chk(opd_scalar[1], 64'h3c);
		wait_idle();
		sx(1'b0, 3'h3, 6'h00, 64'h0, 64'h202);
		sx(1'b0, 3'h3, 6'h3f, 64'h0, 64'h241);
		$display("test same done");
	endtask : t_same

	initial begin
		repeat (3) @(posedge clock);
		#1;
		rst_n = 1'b1;
		chk(ec_r, 7'h40);
		chk(chan_busy_r, 4'h0);
		t_load();
		t_chain(3'h2, 3'h3, 0, 1'b0);
		t_chain(3'h4, 3'h5, 8, 1'b1);
		t_same();
		chk(lasts, 6);
		give_verdict();
	end
endmodule : test_vector_register_chaining
`default_nettype wire
